// ===== lcd_cmd_pkg.sv
package lcd_cmd_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h3E;
  localparam int         SEGMENTS      = 36;
  localparam int         COMMONS       = 4;
  localparam logic [5:0] LAST_ADDR     = 6'h23;
  localparam logic [5:0] ADDR_STEP     = 6'h02;
  localparam logic [5:0] NEXT_NIBBLE   = 6'h01;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         NIB_W         = 4;
  localparam int         BYTE_W        = 8;
  localparam int         CODE_W        = 2;
  localparam int         CONT_BIT      = 7;
  localparam int         MODE_ON_BIT   = 3;
  localparam int         MODE_BIAS_BIT = 2;
  localparam int         SYS_HIGH_BIT  = 2;
  localparam int         SYS_RST_BIT   = 1;
  localparam int         SYS_CLK_BIT   = 0;
  localparam int         INV_BIT       = 2;
  localparam int         FRAME_LSB     = 3;
  localparam int         PTR_LOW_W     = 5;
  localparam int         FRAME_80_HZ   = 80;
  localparam int         FRAME_71_HZ   = 71;
  localparam int         FRAME_64_HZ   = 64;
  localparam int         FRAME_53_HZ   = 53;
  localparam int         BLINK_05_MS   = 2000;
  localparam int         BLINK_1_MS    = 1000;
  localparam int         BLINK_2_MS    = 500;
  localparam int         HALF_PER_MS   = 2000;

  typedef enum logic [1:0] {OVR_NORMAL = 2'b00, OVR_OFF = 2'b01,
                            OVR_ON = 2'b10, OVR_OFF_ALT = 2'b11} override_type;
  typedef enum logic [1:0] {BLINK_NONE = 2'b00, BLINK_HALF_HZ = 2'b01,
                            BLINK_ONE_HZ = 2'b10, BLINK_TWO_HZ = 2'b11} blink_type;
  typedef enum logic [1:0] {FRAME_80 = 2'b00, FRAME_71 = 2'b01,
                            FRAME_64 = 2'b10, FRAME_53 = 2'b11} frame_type;
  typedef enum logic [1:0] {LOWEST_POWER_SETTING = 2'b00, REDUCED_POWER_SETTING = 2'b01,
                            NORMAL_POWER_SETTING = 2'b10, HIGH_POWER_SETTING = 2'b11} power_type;
  typedef enum logic [2:0] {CMD_NONE = 3'b000, CMD_MODE = 3'b001, CMD_SYSTEM = 3'b010,
                            CMD_POINTER = 3'b011, CMD_OVERRIDE = 3'b100, CMD_BLINK = 3'b101,
                            CMD_DRIVE = 3'b110} cmd_type;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_ACK_ADDR = 3'b010,
                            ST_WRITE = 3'b011, ST_ACK_WRITE = 3'b100, ST_READ = 3'b101,
                            ST_ACK_READ = 3'b110} link_state_type;

  typedef struct packed {
    logic         display_on;
    logic         bias_select_bit;
    logic         pointer_high_bit;
    logic         clock_source_bit;
    override_type override_code;
    blink_type    blink_code;
    frame_type    frame_rate_code;
    logic         inversion_select_bit;
    power_type    power_code;
  } lcd_config_type;

  typedef struct packed {
    logic [COMMONS-1:0]  common_line;
    logic [SEGMENTS-1:0] segment_line;
  } lcd_drive_type;

  localparam lcd_config_type CONFIG_RESET = '{display_on: 1'b0, bias_select_bit: 1'b0,
    pointer_high_bit: 1'b0, clock_source_bit: 1'b0, override_code: OVR_NORMAL,
    blink_code: BLINK_NONE, frame_rate_code: FRAME_80, inversion_select_bit: 1'b0,
    power_code: NORMAL_POWER_SETTING};
  localparam lcd_drive_type DRIVE_SUPPLY = '{common_line: '1, segment_line: '1};
endpackage

// ===== lcd_line_sync.sv
`timescale 1ns/10ps
module lcd_line_sync (
  input  logic i_clk,
  input  logic i_nrst,
  input  logic i_scl,
  input  logic i_sda,
  input  logic i_ext,
  output logic o_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop,
  output logic o_ext_rise
);
  // bit 2 scl, bit 1 sda, bit 0 external clock
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      prev_q <= 3'h7;
    end else begin
      meta_q <= {i_scl, i_sda, i_ext};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_sda      = sync_q[1];
  assign o_scl_rise = sync_q[2] & ~prev_q[2];
  assign o_scl_fall = ~sync_q[2] & prev_q[2];
  // start and stop only count while scl stays high
  assign o_start    = sync_q[2] & prev_q[2] & prev_q[1] & ~sync_q[1];
  assign o_stop     = sync_q[2] & prev_q[2] & ~prev_q[1] & sync_q[1];
  assign o_ext_rise = sync_q[0] & ~prev_q[0];
endmodule // lcd_line_sync

// ===== lcd_cmd_core.sv
`timescale 1ns/10ps
module lcd_cmd_core #(
  parameter int MCLK_HZ       = 40_000_000,
  parameter int SYS_CLOCK_HZ  = 32_000
) (
  input  logic                       I_MCLK,
  input  logic                       I_NRST,
  input  logic                       I_SCL,
  input  logic                       I_SDA,
  output logic                       O_SDA_OUT,
  output logic                       O_SDA_OE,
  input  logic                       I_EXTERNAL_CLOCK_PIN,
  output lcd_cmd_pkg::lcd_config_type O_CONFIG,
  output lcd_cmd_pkg::lcd_drive_type  O_DRIVE
);
  import lcd_cmd_pkg::*;

  localparam int OSC_DIV = MCLK_HZ / SYS_CLOCK_HZ;
  localparam int OSC_W   = $clog2(OSC_DIV + 1);
  localparam int CNT_W   = $clog2(SYS_CLOCK_HZ + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
  localparam logic [CNT_W-1:0] QF_80 = CNT_W'(SYS_CLOCK_HZ / (FRAME_80_HZ * COMMONS) - 1);
  localparam logic [CNT_W-1:0] QF_71 = CNT_W'(SYS_CLOCK_HZ / (FRAME_71_HZ * COMMONS) - 1);
  localparam logic [CNT_W-1:0] QF_64 = CNT_W'(SYS_CLOCK_HZ / (FRAME_64_HZ * COMMONS) - 1);
  localparam logic [CNT_W-1:0] QF_53 = CNT_W'(SYS_CLOCK_HZ / (FRAME_53_HZ * COMMONS) - 1);
  // wide product: a fast simulation clock overflows a 32-bit int here
  localparam logic [CNT_W-1:0] BH_05 =
    CNT_W'(longint'(SYS_CLOCK_HZ) * BLINK_05_MS / HALF_PER_MS - 1);
  localparam logic [CNT_W-1:0] BH_1  =
    CNT_W'(longint'(SYS_CLOCK_HZ) * BLINK_1_MS / HALF_PER_MS - 1);
  localparam logic [CNT_W-1:0] BH_2  =
    CNT_W'(longint'(SYS_CLOCK_HZ) * BLINK_2_MS / HALF_PER_MS - 1);

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);

  link_state_type     state_q;
  lcd_config_type     cfg_q;
  lcd_drive_type      drive_q;
  cmd_type            cmd;
  logic [3:0]         bit_cnt_q;
  logic [7:0]         shift_q;
  logic [7:0]         rd_byte;
  logic               sda_oe_q;
  logic               read_q;
  logic               mack_q;
  logic               rx_done_q;
  logic               rd_adv_q;
  logic               data_mode_q;
  logic               data_wr;
  logic [5:0]         ptr_q;
  logic [5:0]         hi_addr;
  logic [5:0]         inc_addr;
  logic [NIB_W-1:0]   ram_q [SEGMENTS];
  logic [OSC_W-1:0]   osc_cnt_q;
  logic               osc_tick;
  logic               sys_tick;
  logic [CNT_W-1:0]   qf_cnt_q;
  logic [CNT_W-1:0]   qf_last;
  logic [1:0]         com_idx_q;
  logic [CNT_W-1:0]   blink_cnt_q;
  logic [CNT_W-1:0]   blink_last;
  logic               blank_q;
  logic [SEGMENTS-1:0] seg_d;
  logic               sda_s;
  logic               scl_rise;
  logic               scl_fall;
  logic               start;
  logic               stop;
  logic               ext_rise;

  function automatic logic [5:0] next_addr(input logic [5:0] a, input logic [5:0] step);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, step};
    if (s > {1'b0, LAST_ADDR}) s = s - {1'b0, LAST_ADDR} - 7'h01;
    if (s > {1'b0, LAST_ADDR}) s = 7'h00;
    next_addr = s[5:0];
  endfunction

  function automatic cmd_type decode_cmd(input logic [6:0] b);
    if (b[6:5] == 2'b00) decode_cmd = CMD_POINTER;
    else if (b[6:5] == 2'b01) decode_cmd = CMD_DRIVE;
    else if (b[6:5] == 2'b10) decode_cmd = CMD_MODE;
    else if (b[6:3] == 4'hD) decode_cmd = CMD_SYSTEM;
    else if (b[6:2] == 5'h1F) decode_cmd = CMD_OVERRIDE;
    else if (b[6:2] == 5'h1C) decode_cmd = CMD_BLINK;
    else decode_cmd = CMD_NONE;
  endfunction

  lcd_line_sync u_sync (
    .i_clk      (I_MCLK),
    .i_nrst     (I_NRST),
    .i_scl      (I_SCL),
    .i_sda      (I_SDA),
    .i_ext      (I_EXTERNAL_CLOCK_PIN),
    .o_sda      (sda_s),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start),
    .o_stop     (stop),
    .o_ext_rise (ext_rise)
  );

  // serial slave: shift on scl rise, drive sda after scl fall
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      sda_oe_q  <= 1'b0;
      read_q    <= 1'b0;
      mack_q    <= 1'b0;
      rx_done_q <= 1'b0;
      rd_adv_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rd_adv_q  <= 1'b0;
      if (stop) begin
        state_q  <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start) begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q  <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_WRITE) begin
                rx_done_q <= 1'b1;
                sda_oe_q  <= 1'b1;
                state_q   <= ST_ACK_WRITE;
              end else if (shift_q[7:1] == DEV_ADDR) begin
                sda_oe_q <= 1'b1;
                read_q   <= shift_q[0];
                state_q  <= ST_ACK_ADDR;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_WRITE: begin
            if (scl_fall) begin
              if (state_q == ST_ACK_ADDR && read_q) begin
                shift_q  <= rd_byte;
                sda_oe_q <= ~rd_byte[BYTE_W-1];
                state_q  <= ST_READ;
              end else begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == BYTE_BITS) begin
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
                rd_adv_q  <= 1'b1;
                state_q   <= ST_ACK_READ;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];
              end
            end
          end
          ST_ACK_READ: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_q) begin
                shift_q  <= rd_byte;
                sda_oe_q <= ~rd_byte[BYTE_W-1];
                state_q  <= ST_READ;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE  = sda_oe_q;

  // continuation flag decides whether the next byte is data
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      data_mode_q <= 1'b0;
    end else if (start) begin
      data_mode_q <= 1'b0;
    end else if (rx_done_q && !data_mode_q) begin
      data_mode_q <= ~shift_q[CONT_BIT];
    end
  end

  assign cmd = (rx_done_q && !data_mode_q) ? decode_cmd(shift_q[6:0]) : CMD_NONE;
  assign data_wr  = rx_done_q && data_mode_q;
  assign hi_addr  = next_addr(ptr_q, NEXT_NIBBLE);
  assign inc_addr = next_addr(ptr_q, ADDR_STEP);

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_q <= CONFIG_RESET;
    end else begin
      unique case (cmd)
        CMD_MODE: begin
          cfg_q.display_on      <= shift_q[MODE_ON_BIT];
          cfg_q.bias_select_bit <= shift_q[MODE_BIAS_BIT];
        end
        CMD_SYSTEM: begin
          if (shift_q[SYS_RST_BIT]) begin
            cfg_q <= CONFIG_RESET;
          end else begin
            cfg_q.pointer_high_bit <= shift_q[SYS_HIGH_BIT];
            cfg_q.clock_source_bit <= shift_q[SYS_CLK_BIT];
          end
        end
        CMD_OVERRIDE: cfg_q.override_code <= override_type'(shift_q[CODE_W-1:0]);
        CMD_BLINK:    cfg_q.blink_code <= blink_type'(shift_q[CODE_W-1:0]);
        CMD_DRIVE: begin
          cfg_q.frame_rate_code      <= frame_type'(shift_q[FRAME_LSB +: CODE_W]);
          cfg_q.inversion_select_bit <= shift_q[INV_BIT];
          cfg_q.power_code           <= power_type'(shift_q[CODE_W-1:0]);
        end
        CMD_NONE, CMD_POINTER: begin
        end
      endcase
    end
  end

  assign O_CONFIG = cfg_q;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ptr_q <= 6'h00;
    end else if (cmd == CMD_SYSTEM && shift_q[SYS_RST_BIT]) begin
      ptr_q <= 6'h00;
    end else if (cmd == CMD_POINTER) begin
      ptr_q <= {cfg_q.pointer_high_bit, shift_q[PTR_LOW_W-1:0]};
    end else if (data_wr || rd_adv_q) begin
      ptr_q <= inc_addr;
    end
  end

  // memory is only written by data bytes, never by the override
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < SEGMENTS; i++) begin
        ram_q[i] <= '0;
      end
    end else if (data_wr) begin
      if (ptr_q <= LAST_ADDR) begin
        ram_q[ptr_q] <= shift_q[NIB_W-1:0];
      end
      ram_q[hi_addr] <= shift_q[BYTE_W-1:NIB_W];
    end
  end

  always_comb begin
    rd_byte = {ram_q[hi_addr], (ptr_q <= LAST_ADDR) ? ram_q[ptr_q] : 4'h0};
  end

  // oscillator stopped in standby to save power
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      osc_cnt_q <= '0;
    end else if (!cfg_q.display_on || cfg_q.clock_source_bit || osc_cnt_q == OSC_LAST) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + OSC_W'(1);
    end
  end

  assign osc_tick = !cfg_q.clock_source_bit && osc_cnt_q == OSC_LAST;
  assign sys_tick = cfg_q.display_on && (cfg_q.clock_source_bit ? ext_rise : osc_tick);

  always_comb begin
    unique case (cfg_q.frame_rate_code)
      FRAME_80: qf_last = QF_80;
      FRAME_71: qf_last = QF_71;
      FRAME_64: qf_last = QF_64;
      FRAME_53: qf_last = QF_53;
    endcase
    unique case (cfg_q.blink_code)
      BLINK_NONE:    blink_last = '0;
      BLINK_HALF_HZ: blink_last = BH_05;
      BLINK_ONE_HZ:  blink_last = BH_1;
      BLINK_TWO_HZ:  blink_last = BH_2;
    endcase
  end

  // one common per quarter frame
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      qf_cnt_q  <= '0;
      com_idx_q <= 2'h0;
    end else if (sys_tick) begin
      if (qf_cnt_q >= qf_last) begin
        qf_cnt_q  <= '0;
        com_idx_q <= com_idx_q + 2'h1;
      end else begin
        qf_cnt_q <= qf_cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      blink_cnt_q <= '0;
      blank_q     <= 1'b0;
    end else if (cfg_q.blink_code == BLINK_NONE) begin
      blink_cnt_q <= '0;
      blank_q     <= 1'b0;
    end else if (sys_tick) begin
      if (blink_cnt_q >= blink_last) begin
        blink_cnt_q <= '0;
        blank_q     <= ~blank_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + CNT_W'(1);
      end
    end
  end

  always_comb begin
    for (int s = 0; s < SEGMENTS; s++) begin
      seg_d[s] = ram_q[s][com_idx_q] && !blank_q;
    end
    if (cfg_q.override_code == OVR_ON) begin
      seg_d = '1;
    end else if (cfg_q.override_code != OVR_NORMAL) begin
      seg_d = '0;
    end
  end

  // display off wins over override, all lines at supply
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      drive_q <= DRIVE_SUPPLY;
    end else if (!cfg_q.display_on) begin
      drive_q <= DRIVE_SUPPLY;
    end else begin
      drive_q.common_line  <= 4'h1 << com_idx_q;
      drive_q.segment_line <= seg_d;
    end
  end

  assign O_DRIVE = drive_q;

  AST_CONT_FLAG: assert property (
    rx_done_q && !data_mode_q && !shift_q[CONT_BIT] && !start |=> data_mode_q)
    else $error("data mode not entered after flag 0");
  AST_RAM_LOW: assert property (
    data_wr && ptr_q <= LAST_ADDR |=> ram_q[$past(ptr_q)] == $past(shift_q[NIB_W-1:0]))
    else $error("low nibble not stored at pointer");
  AST_AUTO_INC: assert property (
    (data_wr || rd_adv_q) |=> ptr_q == $past(inc_addr))
    else $error("pointer did not advance by two");
  AST_ADDR_ACK: assert property (
    state_q == ST_ADDR && scl_fall && bit_cnt_q == BYTE_BITS && shift_q[7:1] == DEV_ADDR
    && !start && !stop |=> O_SDA_OE && state_q == ST_ACK_ADDR)
    else $error("address not acknowledged");
  AST_READ_BIT: assert property (
    state_q == ST_ACK_ADDR && read_q && scl_fall && !start && !stop
    |=> O_SDA_OE == ~$past(rd_byte[BYTE_W-1]))
    else $error("first read bit wrong");
  AST_MODE_ON: assert property (
    cmd == CMD_MODE |=> cfg_q.display_on == $past(shift_q[MODE_ON_BIT]))
    else $error("display on bit not taken");
  AST_BIAS: assert property (
    cmd == CMD_MODE |=> cfg_q.bias_select_bit == $past(shift_q[MODE_BIAS_BIT]))
    else $error("bias bit not taken");
  AST_SOFT_RESET: assert property (
    cmd == CMD_SYSTEM && shift_q[SYS_RST_BIT] |=> cfg_q == CONFIG_RESET && ptr_q == 6'h00)
    else $error("soft reset did not restore defaults");
  AST_POINTER_SET: assert property (
    cmd == CMD_POINTER
    |=> ptr_q == {$past(cfg_q.pointer_high_bit), $past(shift_q[PTR_LOW_W-1:0])})
    else $error("pointer load wrong");
  AST_WRAP: assert property (
    (data_wr || rd_adv_q) && ptr_q == LAST_ADDR - NEXT_NIBBLE |=> ptr_q == 6'h00)
    else $error("pointer did not wrap");
  AST_ALL_ON: assert property (
    cfg_q.display_on && cfg_q.override_code == OVR_ON |=> O_DRIVE.segment_line == '1)
    else $error("all pixel on not driven");
  AST_OFF_SUPPLY: assert property (
    !cfg_q.display_on |=> O_DRIVE == DRIVE_SUPPLY)
    else $error("outputs not at supply while off");
  AST_EXT_TICK: assert property (
    cfg_q.display_on && cfg_q.clock_source_bit && ext_rise && qf_cnt_q < qf_last
    |=> qf_cnt_q == $past(qf_cnt_q) + CNT_W'(1))
    else $error("external pin edge did not advance timing");
  AST_NO_BLANK: assert property (
    cfg_q.blink_code == BLINK_NONE |=> !blank_q)
    else $error("blank while blinking off");

  COV_DATA_WRITE: cover property (data_wr ##[1:1000] data_wr);
  COV_READ_BYTE: cover property (rd_adv_q);
  COV_SOFT_RESET: cover property (cmd == CMD_SYSTEM && shift_q[SYS_RST_BIT]);
  COV_BLINK: cover property (!blank_q ##1 blank_q);
endmodule // lcd_cmd_core

// ===== i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // scl driven high, sda released to idle high through the pull-up
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // also serves as repeated start; ends with scl low
  task automatic start();
    o_sda_low = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b1;
    tick(8);
    o_scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda_low = 1'b0;
    tick(8);
  endtask
  // data only changes while scl is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    r = i_sda;
    o_scl = 1'b0;
    tick(4);
  endtask
  // msb first, ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule // i2c_host_model

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  import lcd_cmd_pkg::*;
  logic           I_MCLK, I_NRST, I_EXTERNAL_CLOCK_PIN, scl, host_low, sda_oe, sda_out, ack;
  wire            sda_wire = !(host_low || sda_oe);
  lcd_config_type cfg, exp_cfg;
  lcd_drive_type  drv;
  logic [7:0]     rd;
  logic [7:0]     chain [8] = '{8'hBC, 8'hCC, 8'hF2, 8'hFE, 8'hEC, 8'h02, 8'h65, 8'h87};
  int             fails, n_tests, cycles;
  lcd_cmd_core #(.SYS_CLOCK_HZ(2_000_000)) lcd_cmd_core_i (.I_MCLK(I_MCLK), .I_NRST(I_NRST),
    .I_SCL(scl), .I_SDA(sda_wire), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
    .I_EXTERNAL_CLOCK_PIN(I_EXTERNAL_CLOCK_PIN), .O_CONFIG(cfg), .O_DRIVE(drv));
  i2c_host_model i2c_host_model_i (.i_clk(I_MCLK), .i_sda(sda_wire), .o_scl(scl),
    .o_sda_low(host_low));
  initial begin
    I_MCLK = 1'b0;
    forever #12.5 I_MCLK = ~I_MCLK;
  end
  initial begin
    I_EXTERNAL_CLOCK_PIN = 1'b0;
    forever #100 I_EXTERNAL_CLOCK_PIN = ~I_EXTERNAL_CLOCK_PIN;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hung transfer would never return
  always @(posedge I_MCLK) begin
    cycles++;
    if (cycles == 40000) begin
      $display("unexpected at %0t: run too long", $time);
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %0h", $time, what, got);
      fails++;
    end
  endtask
  task automatic send(input logic [7:0] b);
    i2c_host_model_i.xfer(b, 1'b1, rd, ack);
    check(ack, 1'b0, "missing ack");
  endtask
  task automatic get(input logic [7:0] exp, input logic last);
    i2c_host_model_i.xfer(8'hFF, last, rd, ack);
    check(rd, exp, "read data");
  endtask
  initial begin
    I_NRST = 1'b0;
    repeat (16) @(posedge I_MCLK);
    #2 I_NRST = 1'b1;
    check(cfg, CONFIG_RESET, "reset config");
    check(drv, DRIVE_SUPPLY, "reset drive");
    check(sda_out, 1'b0, "sda drive level");
    i2c_host_model_i.tick(60); // quiet time after power-up
    // command chain ends in address-set with bit7 low, then data
    i2c_host_model_i.start();
    send(8'h7C);
    foreach (chain[i])
      send(chain[i]);
    i2c_host_model_i.stop();
    exp_cfg = '{1'b1, 1'b1, 1'b1, 1'b0, OVR_ON, BLINK_ONE_HZ, FRAME_53, 1'b1,
                LOWEST_POWER_SETTING};
    check(cfg, exp_cfg, "config");
    i2c_host_model_i.tick(200);
    check(drv.segment_line, {SEGMENTS{1'b1}}, "all on");
    i2c_host_model_i.start();
    send(8'h7C);
    send(8'h7D);
    i2c_host_model_i.stop();
    i2c_host_model_i.tick(200);
    check(drv.segment_line, {SEGMENTS{1'b0}}, "all off");
    $display("test config done");
    // pointer 0x22 keeps its high bit; read wraps past 0x23
    i2c_host_model_i.start();
    send(8'h7C);
    send(8'h02);
    i2c_host_model_i.start();
    send(8'h7D);
    get(8'h65, 1'b0);
    get(8'h87, 1'b1);
    i2c_host_model_i.stop();
    $display("test memory done");
    i2c_host_model_i.start();
    i2c_host_model_i.xfer(8'h70, 1'b1, rd, ack);
    check(ack, 1'b1, "foreign address acked");
    i2c_host_model_i.stop();
    $display("test address done");
    // external clock select, then display off
    i2c_host_model_i.start();
    send(8'h7C);
    send(8'hE9);
    send(8'h40);
    i2c_host_model_i.stop();
    i2c_host_model_i.tick(4);
    check(cfg.clock_source_bit, 1'b1, "clock source");
    check(drv, DRIVE_SUPPLY, "display off");
    $display("test standby done");
    // stop already sent; soft reset with pointer high bit zero
    i2c_host_model_i.start();
    send(8'h7C);
    send(8'h6A);
    i2c_host_model_i.stop();
    check(cfg, CONFIG_RESET, "soft reset");
    $display("test soft reset done");
    report_and_stop();
  end
endmodule // testbench
